/* File: csc_pkg.sv */
// Purpose: Shared constants and types for the charger supervision block
// Assumes: 250 MHz system clock, Avalon-MM register slave
// Notes: Times are given in their own unit, cycle counts derived from them
package csc_pkg;
  localparam int unsigned CLK_HZ = 250_000_000;
  localparam int unsigned INT_PULSE_US = 256;
  localparam int unsigned INT_PULSE_CYC = INT_PULSE_US * (CLK_HZ / 1_000_000);
  localparam int unsigned BLINK_HALF_MS = 500;
  localparam int unsigned BLINK_HALF_CYC = BLINK_HALF_MS * (CLK_HZ / 1_000);
  localparam int unsigned DEGLITCH_MS = 10;
  localparam int unsigned DEGLITCH_CYC = DEGLITCH_MS * (CLK_HZ / 1_000);
  localparam int unsigned LONG_PRESS_S = 15;
  localparam longint unsigned LONG_PRESS_CYC = 64'(LONG_PRESS_S) * 64'(CLK_HZ);
  localparam int unsigned SWITCH_RST_MS = 250;
  localparam int unsigned SWITCH_RST_CYC = SWITCH_RST_MS * (CLK_HZ / 1_000);
  localparam int unsigned SHIP_DLY_S = 10;
  localparam longint unsigned SHIP_DLY_CYC = 64'(SHIP_DLY_S) * 64'(CLK_HZ);
  localparam int unsigned PULSE_STEP_MS = 100;
  localparam int unsigned PULSE_STEP_CYC = PULSE_STEP_MS * (CLK_HZ / 1_000);
  localparam int unsigned PULSE_UP_STEPS = 6;
  localparam int unsigned PULSE_DN_STEPS = 3;

  // Register byte offsets
  localparam logic [3:0] OFS_CTRL = 4'h0;
  localparam logic [3:0] OFS_LIMIT = 4'h4;
  localparam logic [3:0] OFS_STATUS = 4'h8;
  localparam logic [3:0] OFS_FAULT = 4'hC;
  // CTRL fields
  localparam int CB_STATE_DIS = 0;
  localparam int CB_SHIP_REQ = 1;
  localparam int CB_SHIP_DLY = 2;
  localparam int CB_BTN_RST_EN = 3;
  localparam int CB_PULSE_EN = 4;
  localparam int CB_RAISE = 5;
  localparam int CB_LOWER = 6;
  localparam int CB_PIN_LIM_EN = 7;
  localparam int CB_REG_RST = 8;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0008;
  localparam logic [5:0] LIMIT_RESET = 6'h08;
  localparam logic [5:0] LIMIT_100MA = 6'h00;
  // Fault codes and charge-state codes
  localparam logic [1:0] FC_NONE = 2'h0;
  localparam logic [1:0] FC_OVP = 2'h1;
  localparam logic [1:0] FC_THERMAL = 2'h2;
  localparam logic [1:0] FC_TIMER = 2'h3;
  localparam logic [1:0] CS_DONE = 2'h3;

  typedef struct packed {
    logic vbus_above_uvlo;
    logic vbus_above_bat;
    logic vbus_below_ovp;
    logic vbus_good_loaded;
    logic input_overvoltage;
    logic sys_overvoltage;
    logic thermal_shutdown;
    logic thermal_hys_ok;
    logic thermal_regulating;
    logic thermistor_fault;
    logic timer_fault;
    logic boost_mode;
    logic battery_only;
    logic charge_disabled;
    logic source_identified;
    logic [1:0] charge_state_code;
  } csc_cond_t;

  typedef struct packed {
    logic meas_vbat;
    logic meas_vsys;
    logic meas_vts;
    logic meas_vbus;
    logic meas_ichg;
  } csc_meas_t;
endpackage

/* File: csc_timer.sv */
// Purpose: Down-counting interval timer
// Assumes: Start reloads, done is a one-cycle pulse
// Notes: Width set by caller
`timescale 1ns/100ps
module csc_timer #(
  parameter int W = 32
) (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic ce_in,
  input wire logic start_in,
  input wire logic stop_in,
  input wire logic [W-1:0] len_in,
  output logic busy_out,
  output logic done_out
);
  logic [W-1:0] cnt;
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      cnt <= '0;
      busy_out <= 1'b0;
      done_out <= 1'b0;
    end else if (ce_in) begin
      done_out <= 1'b0;
      if (stop_in) begin
        busy_out <= 1'b0;
      end else if (start_in) begin
        cnt <= len_in;
        busy_out <= 1'b1;
      end else if (busy_out) begin
        if (cnt <= W'(1)) begin
          busy_out <= 1'b0;
          done_out <= 1'b1;
        end else begin
          cnt <= cnt - W'(1);
        end
      end
    end
  end
endmodule

/* File: csc_deglitch.sv */
// Purpose: Pin synchroniser with stable-level deglitch
// Assumes: Asynchronous pin input
// Notes: Output changes only after the level holds for len cycles
`timescale 1ns/100ps
module csc_deglitch #(
  parameter int W = 24
) (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic ce_in,
  input wire logic pin_in,
  input wire logic [W-1:0] len_in,
  output logic level_out
);
  logic meta;
  logic sync;
  logic [W-1:0] cnt;
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      meta <= 1'b1;
      sync <= 1'b1;
    end else if (ce_in) begin
      meta <= pin_in;
      sync <= meta;
    end
  end
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      cnt <= '0;
      level_out <= 1'b1;
    end else if (ce_in) begin
      if (sync == level_out) begin
        cnt <= '0;
      end else if (cnt >= len_in) begin
        level_out <= sync;
        cnt <= '0;
      end else begin
        cnt <= cnt + W'(1);
      end
    end
  end
endmodule

/* File: csc_supervisor.sv */
// Purpose: Charger status pins, interrupt pulses, fault latch, switch and pulse control
// Assumes: Analog conditions arrive synchronous to clk_sys_in; button pin is async
// Notes: Registers reached over Avalon-MM, one wait state on every access
`timescale 1ns/100ps
// Summary of operation
// - Measurement enables follow mode; bus excluded battery-only, current only when charging.
// - Power-good low only when all four input conditions hold.
// - State pin driven low while charging, recharge included.
// - State pin released when done, asleep or charge disabled.
// - State pin blinks at 1 Hz during fault suspends.
// - Disable bit stops state pin driving.
// - 256 us interrupt pulse on source, good input, removal, done, fault other than thermistor.
// - Faults latch and block new fault interrupts until read and clear.
// - Fault read returns latched value then reloads live conditions.
// - Ship request opens switch now or after entry delay.
// - Ship mode exits on adapter, bit clear, register reset, button fall.
// - Long button press without input opens switch for reset interval.
// - Button reset inhibited when its enable bit is zero.
// - Pulse sequence alternates limit with 100 mA, then clears request.
// - Clearing protocol enable aborts sequence and restores limit.
// - Direction writes ignored while protocol disabled.
// - Effective limit is min of pin and register when pin enabled.
// - Thermal regulation blocks termination, halves timer, sets flag.
// - Buck thermal shutdown opens converter and switch, code 10, interrupt.
// - Boost thermal shutdown opens switch until a ship-mode exit.
// - Input overvoltage stops switching, code 01, interrupt.
// - Termination gives state code 11 and an interrupt.
// - Thermistor fault field is always live, never latched.
module csc_supervisor
  import csc_pkg::*;
#(
  parameter int unsigned INT_CYC = INT_PULSE_CYC,
  parameter int unsigned BLINK_CYC = BLINK_HALF_CYC,
  parameter int unsigned DEGL_CYC = DEGLITCH_CYC,
  parameter longint unsigned PRESS_CYC = LONG_PRESS_CYC,
  parameter int unsigned RST_CYC = SWITCH_RST_CYC,
  parameter longint unsigned SHIP_CYC = SHIP_DLY_CYC,
  parameter int unsigned STEP_CYC = PULSE_STEP_CYC
) (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic ce_in,
  input wire logic [3:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  input wire csc_cond_t cond_in,
  input wire logic [5:0] limit_resistor_pin_in,
  input wire logic push_button_in,
  output logic power_good_n_out,
  output logic state_pin_out,
  output logic state_pin_oe_out,
  output logic int_n_out,
  output logic battery_switch_out,
  output logic converter_enable_out,
  output logic [5:0] dynamic_input_limit_out,
  output logic termination_enable_out,
  output logic timer_half_rate_out,
  output csc_meas_t meas_out
);
  logic [31:0] ctrl;
  logic [5:0] input_limit_setting;
  logic [7:0] fault_latch_reg;
  logic fault_int_block;
  logic acc;
  logic rd_fire;
  logic wr_fire;
  logic btn;
  logic btn_q;
  logic pulse_active;
  logic pulse_low;
  logic [3:0] pulse_steps;
  logic blink;
  logic [27:0] blink_cnt;
  logic [19:0] int_cnt;
  logic int_evt;
  logic [36:0] press_cnt;
  logic sw_rst_open;
  logic thermal_boost_trip;
  logic ship_open;
  logic good_now;
  logic good_q;
  logic src_q;
  logic done_q;
  logic [7:0] live_fault;
  logic fault_evt;
  logic [1:0] charge_fault_code;
  logic ship_start;
  logic ship_now;
  logic ship_done;
  logic ship_busy;
  logic rst_start;
  logic rst_done;
  logic rst_busy;
  logic step_start;
  logic step_done;
  logic step_busy;
  logic pulse_en_wr;

  function automatic logic [1:0] fault_code(input csc_cond_t c);
    if (c.input_overvoltage || c.sys_overvoltage) fault_code = FC_OVP;
    else if (c.thermal_shutdown) fault_code = FC_THERMAL;
    else if (c.timer_fault) fault_code = FC_TIMER;
    else fault_code = FC_NONE;
  endfunction

  function automatic logic [5:0] min6(input logic [5:0] a, input logic [5:0] b);
    min6 = (a < b) ? a : b;
  endfunction

  // Bus slave: single wait state keeps read-side effects to one cycle
  assign rd_fire = avs_read_in && acc;
  assign wr_fire = avs_write_in && acc;
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      acc <= 1'b0;
      avs_waitrequest_out <= 1'b1;
      avs_readdata_out <= 32'h0000_0000;
    end else if (ce_in) begin
      acc <= (avs_read_in || avs_write_in) && !acc;
      avs_waitrequest_out <= !((avs_read_in || avs_write_in) && !acc);
      if (avs_read_in && !acc) begin
        case (avs_address_in)
          OFS_CTRL: avs_readdata_out <= ctrl;
          OFS_LIMIT: avs_readdata_out <= {26'h0, input_limit_setting};
          OFS_STATUS: avs_readdata_out <= {24'h0, cond_in.thermal_regulating,
            cond_in.charge_state_code, pulse_active, battery_switch_out,
            dynamic_input_limit_out[2:0]};
          OFS_FAULT: avs_readdata_out <= {24'h0, fault_latch_reg[7:1],
            cond_in.thermistor_fault};
          default: avs_readdata_out <= 32'h0000_0000;
        endcase
      end
    end
  end

  assign pulse_en_wr = avs_writedata_in[CB_PULSE_EN];
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      ctrl <= CTRL_RESET;
      input_limit_setting <= LIMIT_RESET;
    end else if (ce_in) begin
      if (wr_fire && avs_address_in == OFS_CTRL && avs_byteenable_in[0]) begin
        if (avs_writedata_in[CB_REG_RST]) begin
          ctrl <= CTRL_RESET;
        end else begin
          ctrl[3:0] <= avs_writedata_in[3:0];
          ctrl[CB_PULSE_EN] <= pulse_en_wr;
          ctrl[CB_PIN_LIM_EN] <= avs_writedata_in[CB_PIN_LIM_EN];
          if (pulse_en_wr && !pulse_active && ctrl[CB_PULSE_EN]) begin
            // Both set together is illegal; raise takes it
            ctrl[CB_RAISE] <= avs_writedata_in[CB_RAISE];
            ctrl[CB_LOWER] <= avs_writedata_in[CB_LOWER] && !avs_writedata_in[CB_RAISE];
          end else if (!pulse_en_wr) begin
            ctrl[CB_RAISE] <= 1'b0;
            ctrl[CB_LOWER] <= 1'b0;
          end
        end
      end else if (pulse_active && step_done && pulse_steps == 4'h1) begin
        ctrl[CB_RAISE] <= 1'b0;
        ctrl[CB_LOWER] <= 1'b0;
      end
      if (wr_fire && avs_address_in == OFS_LIMIT && avs_byteenable_in[0]) begin
        input_limit_setting <= avs_writedata_in[5:0];
      end
    end
  end

  // Fault latch: live value reloads after each read
  always_comb begin
    live_fault = 8'h00;
    live_fault[7:6] = fault_code(cond_in);
    live_fault[5] = cond_in.sys_overvoltage;
    live_fault[0] = cond_in.thermistor_fault;
  end
  assign charge_fault_code = fault_code(cond_in);
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      fault_latch_reg <= 8'h00;
      fault_int_block <= 1'b0;
    end else if (ce_in) begin
      if (rd_fire && avs_address_in == OFS_FAULT) begin
        fault_latch_reg <= live_fault;
        fault_int_block <= (live_fault[7:1] != 7'h00);
      end else begin
        fault_latch_reg <= fault_latch_reg | live_fault;
        if (fault_evt) fault_int_block <= 1'b1;
      end
    end
  end
  assign fault_evt = (live_fault[7:1] != 7'h00) && !fault_int_block;

  // Event edges for interrupt sources
  assign good_now = cond_in.vbus_above_uvlo && cond_in.vbus_above_bat &&
    cond_in.vbus_below_ovp && cond_in.vbus_good_loaded;
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      good_q <= 1'b0;
      src_q <= 1'b0;
      done_q <= 1'b0;
      power_good_n_out <= 1'b1;
    end else if (ce_in) begin
      good_q <= good_now;
      src_q <= cond_in.source_identified;
      done_q <= (cond_in.charge_state_code == CS_DONE);
      power_good_n_out <= !good_now;
    end
  end
  assign int_evt = (good_now != good_q) || (cond_in.source_identified && !src_q) ||
    ((cond_in.charge_state_code == CS_DONE) && !done_q) || fault_evt;

  // Retriggerable pulse; overlapping events merge into one
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      int_cnt <= '0;
      int_n_out <= 1'b1;
    end else if (ce_in) begin
      if (int_evt) begin
        int_cnt <= 20'(INT_CYC - 1);
        int_n_out <= 1'b0;
      end else if (int_cnt != 20'h0) begin
        int_cnt <= int_cnt - 20'h1;
      end else begin
        int_n_out <= 1'b1;
      end
    end
  end

  // Blink base
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      blink_cnt <= '0;
      blink <= 1'b0;
    end else if (ce_in) begin
      if (blink_cnt >= 28'(BLINK_CYC - 1)) begin
        blink_cnt <= '0;
        blink <= !blink;
      end else begin
        blink_cnt <= blink_cnt + 28'h1;
      end
    end
  end

  // State pin: oe low means driven low
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      state_pin_oe_out <= 1'b1;
      state_pin_out <= 1'b1;
    end else if (ce_in) begin
      state_pin_out <= 1'b0;
      if (ctrl[CB_STATE_DIS]) begin
        state_pin_oe_out <= 1'b1;
      end else if (cond_in.input_overvoltage || cond_in.sys_overvoltage ||
          cond_in.thermistor_fault || cond_in.timer_fault) begin
        state_pin_oe_out <= blink;
      end else if (cond_in.charge_disabled || !cond_in.vbus_above_bat ||
          cond_in.charge_state_code == CS_DONE || cond_in.charge_state_code == 2'h0) begin
        state_pin_oe_out <= 1'b1;
      end else begin
        state_pin_oe_out <= 1'b0;
      end
    end
  end

  // Push button and long press
  csc_deglitch #(.W(24)) u_btn (
    .clk_sys_in(clk_sys_in),
    .rst_in(rst_in),
    .ce_in(ce_in),
    .pin_in(push_button_in),
    .len_in(24'(DEGL_CYC)),
    .level_out(btn)
  );
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      btn_q <= 1'b1;
      press_cnt <= '0;
    end else if (ce_in) begin
      btn_q <= btn;
      if (btn || good_now || ctrl[CB_SHIP_REQ] || !ctrl[CB_BTN_RST_EN] || rst_busy) begin
        press_cnt <= '0;
      end else if (press_cnt < 37'(PRESS_CYC)) begin
        press_cnt <= press_cnt + 37'h1;
      end
    end
  end
  assign rst_start = (press_cnt == 37'(PRESS_CYC) - 37'h1) && !btn && !good_now &&
    !ctrl[CB_SHIP_REQ] && ctrl[CB_BTN_RST_EN] && !rst_busy;
  csc_timer #(.W(32)) u_rst (
    .clk_sys_in(clk_sys_in),
    .rst_in(rst_in),
    .ce_in(ce_in),
    .start_in(rst_start),
    .stop_in(1'b0),
    .len_in(32'(RST_CYC)),
    .busy_out(rst_busy),
    .done_out(rst_done)
  );
  assign sw_rst_open = rst_busy;

  // Ship mode entry
  assign ship_start = wr_fire && avs_address_in == OFS_CTRL && avs_byteenable_in[0] &&
    !avs_writedata_in[CB_REG_RST] && avs_writedata_in[CB_SHIP_REQ] &&
    !ctrl[CB_SHIP_REQ] && avs_writedata_in[CB_SHIP_DLY];
  csc_timer #(.W(40)) u_ship (
    .clk_sys_in(clk_sys_in),
    .rst_in(rst_in),
    .ce_in(ce_in),
    .start_in(ship_start),
    .stop_in(!ctrl[CB_SHIP_REQ] && !ship_start),
    .len_in(40'(SHIP_CYC)),
    .busy_out(ship_busy),
    .done_out(ship_done)
  );
  // Immediate entry only on the request write, so an exit is not undone next cycle
  assign ship_now = wr_fire && avs_address_in == OFS_CTRL && avs_byteenable_in[0] &&
    !avs_writedata_in[CB_REG_RST] && avs_writedata_in[CB_SHIP_REQ] &&
    !ctrl[CB_SHIP_REQ] && !avs_writedata_in[CB_SHIP_DLY];
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      ship_open <= 1'b0;
      thermal_boost_trip <= 1'b0;
    end else if (ce_in) begin
      if ((ship_done || ship_now) && !good_now) begin
        ship_open <= 1'b1;
      end else if (!ctrl[CB_SHIP_REQ] || good_now || (!btn && btn_q)) begin
        ship_open <= 1'b0;
      end
      if (cond_in.boost_mode && cond_in.thermal_shutdown) begin
        thermal_boost_trip <= 1'b1;
      end else if ((!btn && btn_q) || good_now || (wr_fire && avs_address_in == OFS_CTRL &&
          (avs_writedata_in[CB_REG_RST] || !avs_writedata_in[CB_SHIP_REQ]))) begin
        thermal_boost_trip <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      battery_switch_out <= 1'b1;
      converter_enable_out <= 1'b1;
    end else if (ce_in) begin
      battery_switch_out <= !(ship_open || sw_rst_open || thermal_boost_trip ||
        (!cond_in.boost_mode && cond_in.thermal_shutdown));
      converter_enable_out <= !cond_in.input_overvoltage &&
        !(!cond_in.boost_mode && cond_in.thermal_shutdown);
    end
  end

  // Pulse protocol sequencer
  assign step_start = (!pulse_active && ctrl[CB_PULSE_EN] && (ctrl[CB_RAISE] || ctrl[CB_LOWER]))
    || (pulse_active && step_done && pulse_steps != 4'h1);
  csc_timer #(.W(28)) u_step (
    .clk_sys_in(clk_sys_in),
    .rst_in(rst_in),
    .ce_in(ce_in),
    .start_in(step_start),
    .stop_in(!ctrl[CB_PULSE_EN]),
    .len_in(28'(STEP_CYC)),
    .busy_out(step_busy),
    .done_out(step_done)
  );
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      pulse_active <= 1'b0;
      pulse_low <= 1'b0;
      pulse_steps <= '0;
    end else if (ce_in) begin
      if (!ctrl[CB_PULSE_EN]) begin
        pulse_active <= 1'b0;
        pulse_low <= 1'b0;
      end else if (!pulse_active && (ctrl[CB_RAISE] || ctrl[CB_LOWER])) begin
        pulse_active <= 1'b1;
        pulse_low <= 1'b1;
        pulse_steps <= ctrl[CB_RAISE] ? 4'(2 * PULSE_UP_STEPS) : 4'(2 * PULSE_DN_STEPS);
      end else if (pulse_active && step_done) begin
        pulse_low <= !pulse_low;
        pulse_steps <= pulse_steps - 4'h1;
        if (pulse_steps == 4'h1) pulse_active <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      dynamic_input_limit_out <= LIMIT_RESET;
      termination_enable_out <= 1'b1;
      timer_half_rate_out <= 1'b0;
      meas_out <= '0;
    end else if (ce_in) begin
      if (pulse_active && pulse_low) begin
        dynamic_input_limit_out <= LIMIT_100MA;
      end else if (ctrl[CB_PIN_LIM_EN]) begin
        dynamic_input_limit_out <= min6(limit_resistor_pin_in, input_limit_setting);
      end else begin
        dynamic_input_limit_out <= input_limit_setting;
      end
      termination_enable_out <= !cond_in.thermal_regulating;
      timer_half_rate_out <= cond_in.thermal_regulating;
      meas_out.meas_vbat <= 1'b1;
      meas_out.meas_vsys <= 1'b1;
      meas_out.meas_vts <= 1'b1;
      meas_out.meas_vbus <= !cond_in.battery_only;
      meas_out.meas_ichg <= !cond_in.battery_only && !cond_in.boost_mode &&
        !cond_in.charge_disabled;
    end
  end

  a_int_len: assert property (@(posedge clk_sys_in) disable iff (rst_in || !ce_in)
    $fell(int_n_out) |=> !int_n_out [*8]) else $error("interrupt pulse too short");
  property p_pg;
    @(posedge clk_sys_in) disable iff (rst_in || !ce_in)
    !good_now |=> power_good_n_out;
  endproperty
  a_pg: assert property (p_pg) else $error("power good asserted wrongly");
  property p_dis;
    @(posedge clk_sys_in) disable iff (rst_in || !ce_in)
    ctrl[CB_STATE_DIS] |=> state_pin_oe_out;
  endproperty
  a_dis: assert property (p_dis) else $error("state pin driven while disabled");
  property p_ovp;
    @(posedge clk_sys_in) disable iff (rst_in || !ce_in)
    cond_in.input_overvoltage |=> !converter_enable_out;
  endproperty
  a_ovp: assert property (p_ovp) else $error("switching during overvoltage");
  property p_abort;
    @(posedge clk_sys_in) disable iff (rst_in || !ce_in)
    !ctrl[CB_PULSE_EN] |=> !pulse_active;
  endproperty
  a_abort: assert property (p_abort) else $error("pulse not aborted");
  property p_lim;
    @(posedge clk_sys_in) disable iff (rst_in || !ce_in)
    !pulse_active && !ctrl[CB_PIN_LIM_EN] ##1 !pulse_active
      |-> dynamic_input_limit_out == $past(input_limit_setting);
  endproperty
  a_lim: assert property (p_lim) else $error("limit mismatch");
  property p_therm;
    @(posedge clk_sys_in) disable iff (rst_in || !ce_in)
    cond_in.thermal_regulating |=> !termination_enable_out && timer_half_rate_out;
  endproperty
  a_therm: assert property (p_therm) else $error("thermal regulation ignored");
  property p_tsd;
    @(posedge clk_sys_in) disable iff (rst_in || !ce_in)
    cond_in.thermal_shutdown |=> !battery_switch_out;
  endproperty
  a_tsd: assert property (p_tsd) else $error("switch closed in shutdown");
endmodule

/* File: csc_cond_model.sv */
// Purpose: Analog condition source facing the supervisor
// Assumes: Levels synchronous to the system clock
// Notes: Good input raises all four input qualifiers together; overvoltage holds the below-OVP qualifier low
`timescale 1ns/100ps
module csc_cond_model
  import csc_pkg::*;
(
  input wire logic good_in,
  input wire logic ovp_in,
  input wire logic [1:0] state_in,
  output csc_cond_t cond_out
);
  always_comb begin
    cond_out = '0;
    cond_out.vbus_above_uvlo = good_in;
    cond_out.vbus_above_bat = good_in;
    cond_out.vbus_below_ovp = good_in & ~ovp_in;
    cond_out.vbus_good_loaded = good_in;
    cond_out.input_overvoltage = ovp_in;
    cond_out.thermal_hys_ok = 1'b1;
    cond_out.charge_state_code = state_in;
  end
endmodule

/* File: tb.sv */
// Purpose: Self-checking bench for the supervisor
// Assumes: Short interval parameters
// Notes: Seeded xorshift picks pin limit codes
`timescale 1ns/100ps
module tb
  import csc_pkg::*;
;
  localparam int IC = 20;
  logic clk = 0, rst = 1, rd = 0, wr = 0, good = 0, ovp = 0, wq, pg_n, oe, int_n, sw, cen;
  logic ce = 1, btn = 1, term, half;
  logic [3:0] be = 4'hF;
  logic [1:0] st = 0;
  logic [3:0] adr = 0;
  logic [5:0] pin = 6'h3F, lim;
  logic [31:0] wd = 0, rdat, q, seed = 32'h0000CCCA;
  csc_cond_t cond;
  int fails = 0, tests_run = 0, cyc = 0, n;
  csc_cond_model i_mdl (.good_in(good), .ovp_in(ovp), .state_in(st), .cond_out(cond));
  csc_supervisor #(.INT_CYC(IC), .BLINK_CYC(20), .DEGL_CYC(20), .PRESS_CYC(40),
    .RST_CYC(20), .SHIP_CYC(30), .STEP_CYC(20)) i_dut (.clk_sys_in(clk), .rst_in(rst),
    .ce_in(ce), .avs_address_in(adr), .avs_read_in(rd), .avs_write_in(wr),
    .avs_writedata_in(wd), .avs_byteenable_in(be), .avs_readdata_out(rdat),
    .avs_waitrequest_out(wq), .cond_in(cond), .limit_resistor_pin_in(pin),
    .push_button_in(btn), .power_good_n_out(pg_n), .state_pin_out(),
    .state_pin_oe_out(oe), .int_n_out(int_n), .battery_switch_out(sw),
    .converter_enable_out(cen), .dynamic_input_limit_out(lim),
    .termination_enable_out(term), .timer_half_rate_out(half), .meas_out());
  initial forever #2 clk = ~clk;
  function logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task av(input logic w, input logic [3:0] a, input logic [31:0] d);
    int k;
    k = 0;
    wr <= w;
    rd <= !w;
    adr <= a;
    wd <= d;
    do begin
      @(posedge clk);
      k++;
    end while (wq !== 1'b0 && k < 50);
    if (k >= 50) fails++;
    q = rdat;
    wr <= 0;
    rd <= 0;
    @(posedge clk);
  endtask
  task tick(input int c);
    repeat (c) @(posedge clk);
  endtask
  task pulse_len();
    int k;
    k = 0;
    n = 0;
    while (int_n !== 1'b0 && k < 10) begin
      @(posedge clk);
      k++;
    end
    while (int_n === 1'b0 && n < 200) begin
      @(posedge clk);
      n++;
    end
  endtask
  task tally_and_finish();
    if (fails == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails++;
      tally_and_finish();
    end
  end
  initial begin
    tick(5);
    rst <= 0;
    @(posedge clk);
    chk({pg_n, oe, int_n, sw, cen, term, half, lim}, {7'h7E, LIMIT_RESET});
    good <= 1;
    pulse_len(); chk(n, IC);
    chk(pg_n, 0);
    st <= 2'h1; tick(4); chk(oe, 0);
    av(1, OFS_CTRL, 32'h09); tick(3); chk(oe, 1);
    av(1, OFS_CTRL, 32'h08); st <= CS_DONE;
    pulse_len(); chk(n, IC);
    chk(oe, 1);
    ovp <= 1; tick(4); chk({cen, pg_n}, 2'b01);
    av(0, OFS_FAULT, 0); chk(q[7:6], FC_OVP);
    ovp <= 0; tick(4);
    av(0, OFS_FAULT, 0); av(0, OFS_FAULT, 0); chk(q[7:6], FC_NONE);
    ce <= 0; ovp <= 1; tick(4); chk(cen, 1);
    ovp <= 0; ce <= 1; tick(2);
    be <= 4'h0; av(1, OFS_LIMIT, 32'h01); be <= 4'hF;
    av(0, OFS_LIMIT, 0); chk(q[5:0], LIMIT_RESET);
    good <= 0; tick(30);
    av(1, OFS_CTRL, 32'h0A); tick(3); chk(sw, 0);
    btn <= 0; tick(30); chk(sw, 1);
    btn <= 1; tick(30);
    av(1, OFS_CTRL, 32'h08); tick(3); chk(sw, 1);
    btn <= 0; tick(72); chk(sw, 0);
    btn <= 1; tick(40); chk(sw, 1);
    av(1, OFS_CTRL, 32'h00); btn <= 0; tick(72); chk(sw, 1);
    btn <= 1; tick(30);
    av(1, OFS_CTRL, 32'h08); tick(3); chk(sw, 1);
    av(1, OFS_CTRL, 32'h28); tick(30); chk(lim, LIMIT_RESET);
    av(1, OFS_CTRL, 32'h18); av(1, OFS_CTRL, 32'h38);
    n = 0;
    while (lim !== LIMIT_100MA && n < 100) begin
      @(posedge clk);
      n++;
    end
    chk(lim, LIMIT_100MA);
    av(1, OFS_CTRL, 32'h08); tick(3); chk(lim, LIMIT_RESET);
    for (int i = 0; i < 4; i++) begin
      pin <= xs() % 64;
      av(1, OFS_CTRL, 32'h88); tick(3);
      chk(lim, (pin < LIMIT_RESET) ? pin : LIMIT_RESET);
    end
    av(1, OFS_CTRL, 32'h08); tick(3); chk(lim, LIMIT_RESET);
    tally_and_finish();
  end
endmodule
